// file: hdl/ioc_cell.sv
// Module: io cell output, three-state and register control
`timescale 1ns/1ps
`default_nettype none

module ioc_cell (
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    input  wire logic [ioc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [ioc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [ioc_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       config_done,
    input  wire logic                       global_set_clear_net,
    input  wire logic                       input_register_clock,
    input  wire logic                       output_register_clock,
    input  wire logic                       shared_clock_gate,
    input  wire logic                       out_data,
    input  wire logic                       tri_ctrl,
    output logic                            in_data,
    input  wire logic                       pad_in,
    output logic                            pad_out,
    output logic                            pad_oe_n,
    output logic                            pull_up_en,
    output logic                            pull_down_en,
    output logic                            slew_fast
);

    // ==========================================================
    // State
    typedef struct packed {
        ioc_pkg::ioc_cfg_t           cfg;
        ioc_pkg::ioc_phase_t         phase;
        logic [1:0]                  done_sync;
        logic [1:0]                  gsr_sync;
        logic [1:0]                  ik_sync;
        logic [1:0]                  ok_sync;
        logic [1:0]                  pad_sync;
        logic                        ik_prev;
        logic                        ok_prev;
        logic                        in_q;
        logic                        out_q;
        logic                        tri_q;
        logic [ioc_pkg::DATA_W-1:0]  rdata;
    } ioc_state_t;

    ioc_state_t s_q;
    ioc_state_t s_d;

    ioc_pkg::ioc_cfg_t cfg;
    logic              gsr_active;
    logic              ik_edge;
    logic              ok_edge;
    logic              gate;
    logic              in_load;
    logic              out_load;
    logic              data_inv;
    logic              tri_inv;
    logic              data_eff;
    logic              tri_eff;
    logic              cell_driven;
    logic              drive_on;
    logic              force_init;

    assign cfg = s_q.cfg;

    // ==========================================================
    // Clock edges and clock gate
    always_comb begin
        gsr_active = s_q.gsr_sync[1];
        // Active edge picked per register clock by its clock inversion; output and three-state flops share one
        ik_edge = cfg.in_clk_invert ?
                  (s_q.ik_prev & ~s_q.ik_sync[1]) :
                  (~s_q.ik_prev & s_q.ik_sync[1]);
        ok_edge = cfg.out_clk_invert ?
                  (s_q.ok_prev & ~s_q.ok_sync[1]) :
                  (~s_q.ok_prev & s_q.ok_sync[1]);
        // Unwired gate counts as active; no inversion in the cell
        gate = ~cfg.gate_connected | shared_clock_gate;
        in_load  = ik_edge & (gate | ~cfg.gate_in);
        out_load = ok_edge & (gate | ~cfg.gate_out);
        // Init values forced throughout configuration and by the global net only
        force_init = gsr_active | (s_q.phase == ioc_pkg::IOC_CONFIG);
    end

    // ==========================================================
    // Output and three-state path
    always_comb begin
        data_inv = out_data ^ cfg.out_invert;
        tri_inv  = tri_ctrl ^ cfg.tri_invert;
        data_eff = cfg.out_registered ? s_q.out_q : data_inv;
        tri_eff  = cfg.tri_registered ? s_q.tri_q : tri_inv;
        cell_driven = (cfg.pad_mode == ioc_pkg::IOC_PAD_DRIVEN) &&
                      (s_q.phase != ioc_pkg::IOC_CONFIG);
        drive_on = cell_driven & ~tri_eff;
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;

        // Two-flop synchronisers for inputs from other domains
        s_d.done_sync = {s_q.done_sync[0], config_done};
        s_d.gsr_sync  = {s_q.gsr_sync[0], global_set_clear_net};
        s_d.ik_sync   = {s_q.ik_sync[0], input_register_clock};
        s_d.ok_sync   = {s_q.ok_sync[0], output_register_clock};
        s_d.pad_sync  = {s_q.pad_sync[0], pad_in};
        s_d.ik_prev   = s_q.ik_sync[1];
        s_d.ok_prev   = s_q.ok_sync[1];

        // Start-up sequencing
        case (s_q.phase)
            ioc_pkg::IOC_CONFIG: begin
                if (s_q.done_sync[1]) begin
                    s_d.phase = ioc_pkg::IOC_SOFT_START;
                end
            end
            ioc_pkg::IOC_SOFT_START: begin
                // Leave soft start once the output has been on once
                if (drive_on) begin
                    s_d.phase = ioc_pkg::IOC_RUN;
                end
            end
            ioc_pkg::IOC_RUN: begin
                s_d.phase = ioc_pkg::IOC_RUN;
            end
            default: begin
                s_d.phase = ioc_pkg::IOC_CONFIG;
            end
        endcase

        // Input, output and three-state flip-flops
        if (force_init) begin
            s_d.in_q  = cfg.in_init_set;
            s_d.out_q = cfg.out_init_set;
            s_d.tri_q = cfg.tri_init_set;
        end else begin
            if (in_load) begin
                s_d.in_q = s_q.pad_sync[1];
            end
            if (out_load) begin
                s_d.out_q = data_inv;
                s_d.tri_q = tri_inv;
            end
        end

        // Configuration writes accepted only before start-up
        if (reg_wr && reg_addr == ioc_pkg::CFG_OFFSET &&
            s_q.phase == ioc_pkg::IOC_CONFIG) begin
            s_d.cfg = ioc_pkg::ioc_cfg_t'(
                reg_wdata[ioc_pkg::CFG_WIDTH-1:0]);
        end

        // Read data stands in the cycle after the read strobe
        s_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ioc_pkg::CFG_OFFSET: begin
                    s_d.rdata[ioc_pkg::CFG_WIDTH-1:0] = s_q.cfg;
                end
                ioc_pkg::STATUS_OFFSET: begin
                    s_d.rdata[ioc_pkg::ST_STARTED_BIT] =
                        (s_q.phase != ioc_pkg::IOC_CONFIG);
                    s_d.rdata[ioc_pkg::ST_RUN_BIT] =
                        (s_q.phase == ioc_pkg::IOC_RUN);
                    s_d.rdata[ioc_pkg::ST_IN_Q_BIT]  = s_q.in_q;
                    s_d.rdata[ioc_pkg::ST_OUT_Q_BIT] = s_q.out_q;
                    s_d.rdata[ioc_pkg::ST_TRI_Q_BIT] = s_q.tri_q;
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        if (srst) begin
            s_d = '0;
            s_d.cfg   = ioc_pkg::ioc_cfg_t'(ioc_pkg::CFG_RESET);
            s_d.phase = ioc_pkg::IOC_CONFIG;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk) begin
        s_q <= s_d;
    end

    // ==========================================================
    // Outputs
    always_comb begin
        reg_rdata = s_q.rdata;
        in_data   = s_q.in_q;
        pad_out   = data_eff;
        pad_oe_n  = ~drive_on;
        pull_up_en   = (cfg.pad_mode == ioc_pkg::IOC_PAD_PULLUP);
        pull_down_en = (cfg.pad_mode == ioc_pkg::IOC_PAD_PULLDOWN);
        // Limited slew until the cycle after the output is first turned on
        slew_fast = cfg.slew_fast &&
                    (s_q.phase == ioc_pkg::IOC_RUN);
    end

endmodule

`default_nettype wire

// file: hdl/ioc_pkg.sv
// Package: constants and types for the io cell control block
package ioc_pkg;

    // ==========================================================
    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] CFG_OFFSET    = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

    // ==========================================================
    // Configuration field positions
    localparam int CFG_OUT_INV_BIT   = 0;
    localparam int CFG_TRI_INV_BIT   = 1;
    localparam int CFG_OUT_REG_BIT   = 2;
    localparam int CFG_TRI_REG_BIT   = 3;
    localparam int CFG_IN_SET_BIT    = 4;
    localparam int CFG_OUT_SET_BIT   = 5;
    localparam int CFG_TRI_SET_BIT   = 6;
    localparam int CFG_IN_CKINV_BIT  = 7;
    localparam int CFG_OUT_CKINV_BIT = 8;
    localparam int CFG_GATE_IN_BIT   = 9;
    localparam int CFG_GATE_OUT_BIT  = 10;
    localparam int CFG_GATE_CONN_BIT = 11;
    localparam int CFG_SLEW_BIT      = 12;
    localparam int CFG_MODE_LSB      = 13;
    localparam int CFG_WIDTH         = 15;

    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 15'h0000;

    // ==========================================================
    // Status field positions
    localparam int ST_STARTED_BIT = 0;
    localparam int ST_RUN_BIT     = 1;
    localparam int ST_IN_Q_BIT    = 2;
    localparam int ST_OUT_Q_BIT   = 3;
    localparam int ST_TRI_Q_BIT   = 4;

    // ==========================================================
    // Pad modes
    typedef enum logic [1:0] {
        IOC_PAD_PULLUP   = 2'h0,
        IOC_PAD_PULLDOWN = 2'h1,
        IOC_PAD_DRIVEN   = 2'h2,
        IOC_PAD_EXTERNAL = 2'h3
    } ioc_pad_mode_t;

    // ==========================================================
    // Static cell configuration
    typedef struct packed {
        ioc_pad_mode_t pad_mode;
        logic          slew_fast;
        logic          gate_connected;
        logic          gate_out;
        logic          gate_in;
        logic          out_clk_invert;
        logic          in_clk_invert;
        logic          tri_init_set;
        logic          out_init_set;
        logic          in_init_set;
        logic          tri_registered;
        logic          out_registered;
        logic          tri_invert;
        logic          out_invert;
    } ioc_cfg_t;

    // ==========================================================
    // Start-up phases
    typedef enum {
        IOC_CONFIG,
        IOC_SOFT_START,
        IOC_RUN
    } ioc_phase_t;

    // ==========================================================
    // Pad side signals
    typedef struct packed {
        logic pad_out;
        logic pad_oe_n;
        logic pull_up_en;
        logic pull_down_en;
        logic slew_fast;
    } ioc_pad_t;

endpackage

// file: testbench/ioc_cell_chk.sv
// Checker: port assertions for the io cell
`timescale 1ns/1ps
`default_nettype none
module ioc_cell_chk (
    input wire logic                       core_clk,
    input wire logic                       srst,
    input wire logic [ioc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                       reg_rd,
    input wire logic [ioc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                       global_set_clear_net,
    input wire logic                       in_data,
    input wire logic                       pad_oe_n,
    input wire logic                       pull_up_en,
    input wire logic                       pull_down_en,
    input wire logic                       slew_fast
);
    logic seen_q;
    // ==========================================================
    // Pad has been driven once since reset
    always_ff @(posedge core_clk) begin
        if (srst) seen_q <= 1'b0;
        else if (!pad_oe_n) seen_q <= 1'b1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    chk_pull_default: assert property ($past(srst) |-> pull_up_en &&
        pad_oe_n && !slew_fast) else $error("reset pad state wrong");
    chk_pull_excl: assert property (!(pull_up_en && pull_down_en))
        else $error("both pulls on");
    chk_drive_nopull: assert property (!pad_oe_n |->
        !pull_up_en && !pull_down_en) else $error("pull while driven");
    chk_soft_slew: assert property (!seen_q |-> !slew_fast)
        else $error("fast slew before first drive");
    chk_gsr_hold: assert property (global_set_clear_net [*5] |=>
        $stable(in_data)) else $error("input flop moved under global net");
    chk_cfg_static: assert property (seen_q |-> $stable(pull_up_en) &&
        $stable(pull_down_en)) else $error("pull changed in run");
    chk_rdata_idle: assert property (!$past(reg_rd) |->
        reg_rdata == 16'h0000) else $error("read data outside slot");
    chk_rdata_unmapped: assert property ($past(reg_rd) &&
        $past(reg_addr) > ioc_pkg::STATUS_OFFSET |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule
bind ioc_cell ioc_cell_chk u_chk (.core_clk, .srst, .reg_addr, .reg_rd,
    .reg_rdata, .global_set_clear_net, .in_data, .pad_oe_n, .pull_up_en,
    .pull_down_en, .slew_fast);
`default_nettype wire

// file: testbench/ioc_pad_model.sv
// Model: pad wire with pulls and an outside driver
`timescale 1ns/1ps
`default_nettype none
module ioc_pad_model (
    input  wire logic core_clk,
    input  wire logic pad_out,
    input  wire logic pad_oe_n,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    input  wire logic ext_en,
    input  wire logic ext_val,
    output logic      pad_level
);
    logic float_q = 1'b0;
    // A floating pad shows a level that changes every cycle
    always_ff @(posedge core_clk) float_q <= ~float_q;
    always_comb begin
        if (!pad_oe_n) pad_level = pad_out;
        else if (ext_en) pad_level = ext_val;
        else if (pull_up_en) pad_level = 1'b1;
        else if (pull_down_en) pad_level = 1'b0;
        else pad_level = float_q;
    end
endmodule
`default_nettype wire

// file: testbench/test_io_cell_output_and_register_control.sv
// Bench: directed tests of the io cell through its ports
`timescale 1ns/1ps
`default_nettype none
module test_io_cell_output_and_register_control;
    logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, config_done = 0;
    logic global_set_clear_net = 0, input_register_clock = 0;
    logic output_register_clock = 0, shared_clock_gate = 0;
    logic out_data = 0, tri_ctrl = 1, ext_en = 0, ext_val = 0;
    logic [ioc_pkg::ADDR_W-1:0] reg_addr = '0;
    logic [ioc_pkg::DATA_W-1:0] reg_wdata = '0, reg_rdata, d;
    logic in_data, pad_out, pad_oe_n, pull_up_en, pull_down_en, slew_fast;
    logic pad_in;
    int   miscompares = 0, compares = 0, cyc = 0;
    ioc_cell DUT (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .config_done, .global_set_clear_net, .input_register_clock,
        .output_register_clock, .shared_clock_gate, .out_data, .tri_ctrl,
        .in_data, .pad_in, .pad_out, .pad_oe_n, .pull_up_en, .pull_down_en,
        .slew_fast);
    ioc_pad_model u_pad (.core_clk, .pad_out, .pad_oe_n, .pull_up_en,
        .pull_down_en, .ext_en, .ext_val, .pad_level(pad_in));
    always #10 core_clk = ~core_clk;
    // ==========================================================
    // Tasks
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic ck(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic cb(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cw(input string n, input logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        ck(1); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        ck(1); reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        ck(1); reg_addr <= a; reg_rd <= 1'b1;
        ck(1); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic oclk(input logic v);
        ck(1); output_register_clock <= v; ck(6); #1;
    endtask
    task automatic iclk(input logic v);
        ck(1); input_register_clock <= v; ck(6); #1;
    endtask
    task automatic setup(input logic [14:0] c);
        ck(1); srst <= 1'b1; config_done <= 1'b0;
        ck(5); srst <= 1'b0;
        wr(ioc_pkg::CFG_OFFSET, {1'b0, c});
        rd(ioc_pkg::CFG_OFFSET); cw("cfg", {1'b0, c}, d);
        ck(1); config_done <= 1'b1;
        ck(6);
        rd(ioc_pkg::STATUS_OFFSET); cb("started", 1'b1, d[0]);
    endtask
    // ==========================================================
    // Tests
    initial begin
        ck(5); srst <= 1'b0; ck(1); #1;
        cb("pull_up_en", 1'b1, pull_up_en);
        cb("pad_oe_n", 1'b1, pad_oe_n);
        rd(ioc_pkg::CFG_OFFSET); cw("cfg", {1'b0, ioc_pkg::CFG_RESET}, d);
        rd(8'h08); cw("unmapped", 16'h0000, d);
        rd(ioc_pkg::STATUS_OFFSET); cb("started", 1'b0, d[0]);
        $display("test 1 reset done");
        setup(15'h5000);
        #1 cb("pad_oe_n", 1'b1, pad_oe_n);
        ck(1); tri_ctrl <= 1'b0; #2;
        cb("pad_oe_n", 1'b0, pad_oe_n);
        cb("pad_out", 1'b0, pad_out);
        cb("slew_fast", 1'b0, slew_fast);
        ck(2); #1 cb("slew_fast", 1'b1, slew_fast);
        cb("pull_up_en", 1'b0, pull_up_en);
        ck(1); tri_ctrl <= 1'b1; #2 cb("pad_oe_n", 1'b1, pad_oe_n);
        wr(ioc_pkg::CFG_OFFSET, 16'h0000);
        rd(ioc_pkg::CFG_OFFSET); cw("cfg", 16'h5000, d);
        $display("test 2 open drain done");
        setup(15'h4c2f);
        #1 cb("pad_out", 1'b1, pad_out);
        cb("pad_oe_n", 1'b0, pad_oe_n);
        ck(1); out_data <= 1'b1; shared_clock_gate <= 1'b1;
        oclk(1); cb("pad_out", 1'b0, pad_out);
        oclk(0); shared_clock_gate <= 1'b0; out_data <= 1'b0;
        oclk(1); cb("pad_out", 1'b0, pad_out);
        oclk(0); shared_clock_gate <= 1'b1;
        oclk(1); cb("pad_out", 1'b1, pad_out);
        oclk(0); out_data <= 1'b1;
        oclk(1); oclk(0); cb("pad_out", 1'b0, pad_out);
        global_set_clear_net <= 1'b1;
        ck(5); #1 cb("pad_out", 1'b1, pad_out);
        oclk(1); cb("pad_out", 1'b1, pad_out);
        global_set_clear_net <= 1'b0; oclk(0);
        tri_ctrl <= 1'b0; #2 cb("pad_oe_n", 1'b0, pad_oe_n);
        oclk(1); cb("pad_oe_n", 1'b1, pad_oe_n);
        $display("test 3 output flop done");
        ext_en <= 1'b1; ext_val <= 1'b1;
        setup(15'h6a80);
        #1 cb("pull_down_en", 1'b0, pull_down_en);
        cb("pull_up_en", 1'b0, pull_up_en);
        oclk(1); oclk(0); cb("in_data", 1'b0, in_data);
        iclk(1); cb("in_data", 1'b0, in_data);
        iclk(0); cb("in_data", 1'b1, in_data);
        shared_clock_gate <= 1'b0; ext_val <= 1'b0;
        iclk(1); iclk(0); cb("in_data", 1'b1, in_data);
        $display("test 4 input flop done");
        ext_en <= 1'b0;
        setup(15'h2010);
        #1 cb("pull_down_en", 1'b1, pull_down_en);
        cb("in_data", 1'b1, in_data);
        iclk(1); cb("in_data", 1'b0, in_data);
        $display("test 5 pull down done");
        stop_test();
    end
endmodule
`default_nettype wire
